// ==== hw/ecms_regs.svh ====
/*
   register offsets, field positions, reset values and timing counts
   for the external clock mode start-up block.
   assumes it is included by bare name after the package is compiled.
*/
// Functional notes
// - resonator modes count 1024 input oscillations first
// - count restarts after reset, power-up delay, wake
// - core stays frozen while the count runs
// - external logic clock mode bypasses the count
// - external logic clock: input pin, output pin gpio
// - stopped input clock just halts, state kept
// - restarted input clock resumes from held state
// - rc mode drives output pin at rate/4
// - rc with gpio: output pin is gpio
// - logic clock or rc start: 2 instruction cycles
// - switch from internal: one old, one new cycle
// - multiplier adds 2 ms after 1024 cycles
// - resonator mode selects amplifier gain level
// - logic clock mode has medium, high power option
// - high gain resonator high power: highest gain
`ifndef ECMS_REGS_SVH
`define ECMS_REGS_SVH

`define ECMS_OFF_CTRL        8'h00
`define ECMS_OFF_CMD         8'h04
`define ECMS_OFF_STAT        8'h08

`define ECMS_CTRL_CFG_LSB    0
`define ECMS_CTRL_PLL_BIT    4
`define ECMS_CTRL_PWRUP_BIT  5
`define ECMS_CTRL_SRC_BIT    6
`define ECMS_CTRL_RST        7'h41

`define ECMS_CMD_SLEEP_BIT   0
`define ECMS_CMD_WAKE_BIT    1

`define ECMS_START_EDGES     11'h400
`define ECMS_INSTR_EDGES     11'h004
`define ECMS_EXT_START_EDGES (`ECMS_INSTR_EDGES * 11'h002)

`define ECMS_CLK_PERIOD_NS   10
`define ECMS_PLL_WAIT_MS     2
`define ECMS_PLL_WAIT_CYC    (`ECMS_PLL_WAIT_MS * 1000000 / `ECMS_CLK_PERIOD_NS)

`define ECMS_RESP_OKAY       2'b00
`define ECMS_RESP_SLVERR     2'b10

`endif

// ==== hw/ecms_pkg.sv ====
/*
   types shared by the external clock mode start-up block.
   assumes nothing of its surroundings.
*/
package ecms_pkg;

   // oscillator_config_field encodings; codes 8..15 are illegal
   typedef enum logic [3:0] {
      CFG_LOW_GAIN_CRYSTAL    = 4'h0,
      CFG_MEDIUM_GAIN_CRYSTAL = 4'h1,
      CFG_HIGH_GAIN_CRYSTAL_HIPWR  = 4'h2,
      CFG_HIGH_GAIN_CRYSTAL_MEDPWR = 4'h3,
      CFG_EXT_LOGIC_CLOCK_HIPWR    = 4'h4,
      CFG_EXT_LOGIC_CLOCK_MEDPWR   = 4'h5,
      CFG_RC_DIVIDED_CLOCK_OUTPUT           = 4'h6,
      CFG_RC_GPIO             = 4'h7
   } ecms_cfg_t;

   typedef enum logic [2:0] {
      ST_POR    = 3'b000,
      ST_PWRUP  = 3'b001,
      ST_COUNT  = 3'b011,
      ST_PLL    = 3'b010,
      ST_RUN    = 3'b110,
      ST_SLEEP  = 3'b111,
      ST_SWITCH = 3'b101,
      ST_EXT    = 3'b100
   } ecms_state_t;

   typedef enum logic [1:0] {
      GAIN_LOWEST  = 2'h0,
      GAIN_MEDIUM  = 2'h1,
      GAIN_HIGH    = 2'h2,
      GAIN_HIGHEST = 2'h3
   } ecms_gain_t;

endpackage

// ==== hw/ecms_cnt_if.sv ====
/*
   carrier between the top and the input-edge counter.
   assumes one clock domain, clk_sys.
*/
`timescale 1ns/1ns
`default_nettype none
interface ecms_cnt_if;
   logic        clr;
   logic        tick;
   logic [10:0] target;
   logic        done;
   modport owner (output clr, output tick, output target, input done);
   modport counter (input clr, input tick, input target, output done);
endinterface
`default_nettype wire

// ==== hw/ecms_edge_count.sv ====
/*
   counter of clock input edges up to a target, holding at the target.
   assumes tick is a one-cycle pulse per input oscillation.
*/
`timescale 1ns/1ns
`default_nettype none
module ecms_edge_count (
   input  wire logic clk_sys, // system clock
   input  wire logic rst_b,   // async reset, active low
   ecms_cnt_if.counter cnt    // clear, tick, target, done
);
   logic [10:0] count_reg;

   // no time base here: a stopped input clock freezes the count
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         count_reg <= 11'h000;
      end else if (cnt.clr) begin
         count_reg <= 11'h000;
      end else if (cnt.tick && (count_reg != cnt.target)) begin
         count_reg <= count_reg + 11'h001;
      end
   end

   assign cnt.done = (count_reg == cnt.target);
endmodule
`default_nettype wire

// ==== hw/ecms_clkdiv.sv ====
/*
   divide-by-4 of the input oscillation for the clock output pin.
   assumes tick is a one-cycle pulse per input rising edge.
*/
`timescale 1ns/1ns
`default_nettype none
module ecms_clkdiv (
   input  wire logic clk_sys,  // system clock
   input  wire logic rst_b,    // async reset, active low
   input  wire logic en,       // divider enabled
   input  wire logic tick,     // input rising edge
   output var  logic div_out   // rate / 4
);
   logic [1:0] phase_reg;

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         phase_reg <= 2'h0;
      end else if (!en) begin
         phase_reg <= 2'h0;
      end else if (tick) begin
         phase_reg <= phase_reg + 2'h1;
      end
   end

   // two edges high, two low: one output period per four inputs
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         div_out <= 1'b0;
      end else begin
         div_out <= en & phase_reg[1];
      end
   end
endmodule
`default_nettype wire

// ==== hw/ecms_top.sv ====
/*
   external clock mode start-up control with an AXI4-Lite register slave.
   assumes clock_input_pin and lf_osc_tick are synchronous to clk_sys.
*/
// Register access over AXI4-Lite and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "ecms_regs.svh"
module ecms_top #(
   parameter int unsigned PLL_WAIT_CYC = `ECMS_PLL_WAIT_CYC
) (
   input  wire logic        clk_sys,         // system clock
   input  wire logic        rst_b,           // async reset, active low
   input  wire logic [7:0]  s_axi_awaddr,    // write address
   input  wire logic        s_axi_awvalid,   // write address valid
   output var  logic        s_axi_awready,   // write address ready
   input  wire logic [31:0] s_axi_wdata,     // write data
   input  wire logic [3:0]  s_axi_wstrb,     // write strobes
   input  wire logic        s_axi_wvalid,    // write data valid
   output var  logic        s_axi_wready,    // write data ready
   output var  logic [1:0]  s_axi_bresp,     // write response
   output var  logic        s_axi_bvalid,    // write response valid
   input  wire logic        s_axi_bready,    // write response ready
   input  wire logic [7:0]  s_axi_araddr,    // read address
   input  wire logic        s_axi_arvalid,   // read address valid
   output var  logic        s_axi_arready,   // read address ready
   output var  logic [31:0] s_axi_rdata,     // read data
   output var  logic [1:0]  s_axi_rresp,     // read response
   output var  logic        s_axi_rvalid,    // read data valid
   input  wire logic        s_axi_rready,    // read data ready
   input  wire logic        clock_input_pin, // external clock level
   input  wire logic        lf_osc_tick,     // internal osc cycle pulse
   input  wire logic        pwrup_expired,   // power-up delay done
   input  wire logic        wake_evt,        // wake-up from sleep
   output var  logic        core_run,        // core clock gate open
   output var  logic        clock_stable,    // start-up count done
   output var  logic [1:0]  amp_gain,        // amplifier gain
   output var  logic        high_power_opt,  // high power option
   output var  logic        clock_output_pin_o,  // output pin level
   output var  logic        clock_output_pin_oe, // output pin driven
   output var  logic        out_gpio_sel     // output pin is gpio
);
   ecms_cnt_if cnt_bus ();
   ecms_pkg::ecms_state_t state_reg, state_next;
   logic [6:0]  ctrl_reg;
   logic        sleep_cmd_reg, wake_cmd_reg, pin_d_reg, pin_edge, active_src_reg;
   logic        sw_old_seen_reg, pll_done, ext_mode, pll_en, pwrup_en, src_primary;
   logic        hipwr_next, rc_divided_clock_output, gpio_next, wake_any;
   logic [17:0] pll_cnt_reg;
   logic [3:0]  cfg;
   logic [1:0]  gain_next;
   logic        aw_have_reg, w_have_reg, w_lane0_reg, aw_take, w_take, wr_commit, ar_take;
   logic        aw_have_next, w_have_next, bvalid_next, rvalid_next;
   logic [7:0]  aw_addr_reg;
   logic [6:0]  w_data_reg;
   logic [31:0] rdata_next;
   logic [1:0]  rresp_next;

   assign cfg         = ctrl_reg[`ECMS_CTRL_CFG_LSB +: 4];
   assign pll_en      = ctrl_reg[`ECMS_CTRL_PLL_BIT];
   assign pwrup_en    = ctrl_reg[`ECMS_CTRL_PWRUP_BIT];
   assign src_primary = ctrl_reg[`ECMS_CTRL_SRC_BIT];
   assign wake_any    = wake_cmd_reg | wake_evt;

   // bus side
   assign aw_take   = s_axi_awvalid & s_axi_awready;
   assign w_take    = s_axi_wvalid & s_axi_wready;
   assign ar_take   = s_axi_arvalid & s_axi_arready;
   assign wr_commit = aw_have_reg & w_have_reg;

   assign aw_have_next = (aw_have_reg | aw_take) & ~wr_commit;
   assign w_have_next  = (w_have_reg | w_take) & ~wr_commit;
   assign bvalid_next  = (s_axi_bvalid & ~s_axi_bready) | wr_commit;
   assign rvalid_next  = (s_axi_rvalid & ~s_axi_rready) | ar_take;

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         aw_have_reg   <= 1'b0;
         w_have_reg    <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
      end else begin
         aw_have_reg   <= aw_have_next;
         w_have_reg    <= w_have_next;
         s_axi_awready <= ~aw_have_next & ~bvalid_next;
         s_axi_wready  <= ~w_have_next & ~bvalid_next;
         s_axi_bvalid  <= bvalid_next;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         aw_addr_reg <= 8'h00;
         w_data_reg  <= 7'h00;
         w_lane0_reg <= 1'b0;
      end else begin
         if (aw_take) begin
            aw_addr_reg <= s_axi_awaddr;
         end
         if (w_take) begin
            w_data_reg  <= s_axi_wdata[6:0];
            w_lane0_reg <= s_axi_wstrb[0];
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         s_axi_bresp <= `ECMS_RESP_OKAY;
      end else if (wr_commit) begin
         unique case (aw_addr_reg)
            `ECMS_OFF_CTRL, `ECMS_OFF_CMD, `ECMS_OFF_STAT: s_axi_bresp <= `ECMS_RESP_OKAY;
            default: s_axi_bresp <= `ECMS_RESP_SLVERR;
         endcase
      end
   end

   // software-steered configuration
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_reg <= `ECMS_CTRL_RST;
      end else if (wr_commit && w_lane0_reg && aw_addr_reg == `ECMS_OFF_CTRL) begin
         ctrl_reg <= w_data_reg;
      end
   end

   // command pulses last one cycle; ignored outside their state
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         sleep_cmd_reg <= 1'b0;
         wake_cmd_reg  <= 1'b0;
      end else begin
         sleep_cmd_reg <= wr_commit && w_lane0_reg && aw_addr_reg == `ECMS_OFF_CMD
                          && w_data_reg[`ECMS_CMD_SLEEP_BIT];
         wake_cmd_reg  <= wr_commit && w_lane0_reg && aw_addr_reg == `ECMS_OFF_CMD
                          && w_data_reg[`ECMS_CMD_WAKE_BIT];
      end
   end

   always_comb begin
      rresp_next = `ECMS_RESP_OKAY;
      rdata_next = 32'h0000_0000;
      unique case (s_axi_araddr)
         `ECMS_OFF_CTRL: begin
            rdata_next = {25'h0000000, ctrl_reg};
         end
         `ECMS_OFF_CMD: rdata_next = 32'h0000_0000;
         `ECMS_OFF_STAT: begin
            rdata_next = {23'h000000, high_power_opt, amp_gain, active_src_reg,
                          core_run, clock_stable, state_reg};
         end
         default: begin
            rresp_next = `ECMS_RESP_SLVERR;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= `ECMS_RESP_OKAY;
      end else begin
         s_axi_arready <= ~rvalid_next;
         s_axi_rvalid  <= rvalid_next;
         if (ar_take) begin
            s_axi_rdata <= rdata_next;
            s_axi_rresp <= rresp_next;
         end
      end
   end

   // mode decode
   always_comb begin
      ext_mode  = 1'b1;
      gain_next = ecms_pkg::GAIN_LOWEST;
      hipwr_next = 1'b0;
      rc_divided_clock_output = 1'b0;
      gpio_next = 1'b0;
      unique case (cfg)
         ecms_pkg::CFG_LOW_GAIN_CRYSTAL: begin
            ext_mode  = 1'b0;
            gain_next = ecms_pkg::GAIN_LOWEST;
         end
         ecms_pkg::CFG_MEDIUM_GAIN_CRYSTAL: begin
            ext_mode  = 1'b0;
            gain_next = ecms_pkg::GAIN_MEDIUM;
         end
         ecms_pkg::CFG_HIGH_GAIN_CRYSTAL_HIPWR: begin
            ext_mode  = 1'b0;
            gain_next = ecms_pkg::GAIN_HIGHEST;
            hipwr_next = 1'b1;
         end
         ecms_pkg::CFG_HIGH_GAIN_CRYSTAL_MEDPWR: begin
            ext_mode  = 1'b0;
            gain_next = ecms_pkg::GAIN_HIGH;
         end
         ecms_pkg::CFG_EXT_LOGIC_CLOCK_HIPWR: begin
            hipwr_next = 1'b1;
            gpio_next = 1'b1;
         end
         ecms_pkg::CFG_EXT_LOGIC_CLOCK_MEDPWR: begin
            gpio_next = 1'b1;
         end
         ecms_pkg::CFG_RC_DIVIDED_CLOCK_OUTPUT: begin
            rc_divided_clock_output = 1'b1;
         end
         ecms_pkg::CFG_RC_GPIO: begin
            gpio_next = 1'b1;
         end
         default: begin
            gpio_next = 1'b1; // illegal codes fall back to logic clock, medium power
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         amp_gain            <= ecms_pkg::GAIN_LOWEST;
         high_power_opt      <= 1'b0;
         out_gpio_sel        <= 1'b0;
         clock_output_pin_oe <= 1'b0;
      end else begin
         amp_gain            <= gain_next;
         high_power_opt      <= hipwr_next;
         out_gpio_sel        <= gpio_next;
         clock_output_pin_oe <= rc_divided_clock_output;
      end
   end

   // input pin level registered on the system clock in every mode, for edge detection
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         pin_d_reg <= 1'b0;
      end else begin
         pin_d_reg <= clock_input_pin;
      end
   end

   // count and switch waits use input edges, so a stopped clock holds those states; the multiplier wait counts system clocks
   assign pin_edge = clock_input_pin & ~pin_d_reg;

   // counter clears outside its states, so each entry restarts it
   assign cnt_bus.clr    = (state_reg != ecms_pkg::ST_COUNT) && (state_reg != ecms_pkg::ST_EXT);
   assign cnt_bus.tick   = pin_edge;
   assign cnt_bus.target = (state_reg == ecms_pkg::ST_COUNT) ?
                           `ECMS_START_EDGES : `ECMS_EXT_START_EDGES;

   ecms_edge_count u_startup_cnt (
      .clk_sys (clk_sys),
      .rst_b   (rst_b),
      .cnt     (cnt_bus)
   );

   ecms_clkdiv u_clkdiv (
      .clk_sys (clk_sys),
      .rst_b   (rst_b),
      .en      (rc_divided_clock_output),
      .tick    (pin_edge),
      .div_out (clock_output_pin_o)
   );

   // multiplier lock wait in system clocks, not input edges
   assign pll_done = (pll_cnt_reg == 18'(PLL_WAIT_CYC - 1));

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         pll_cnt_reg <= 18'h00000;
      end else if (state_reg != ecms_pkg::ST_PLL) begin
         pll_cnt_reg <= 18'h00000;
      end else if (!pll_done) begin
         pll_cnt_reg <= pll_cnt_reg + 18'h00001;
      end
   end

   // switch needs one internal-osc cycle, then one input cycle
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         sw_old_seen_reg <= 1'b0;
      end else if (state_reg != ecms_pkg::ST_SWITCH) begin
         sw_old_seen_reg <= 1'b0;
      end else if (lf_osc_tick) begin
         sw_old_seen_reg <= 1'b1;
      end
   end

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         ecms_pkg::ST_POR: begin
            state_next = pwrup_en ? ecms_pkg::ST_PWRUP :
                         ext_mode ? ecms_pkg::ST_EXT : ecms_pkg::ST_COUNT;
         end
         ecms_pkg::ST_PWRUP: begin
            if (pwrup_expired) begin
               state_next = ext_mode ? ecms_pkg::ST_EXT : ecms_pkg::ST_COUNT;
            end
         end
         ecms_pkg::ST_COUNT, ecms_pkg::ST_EXT: begin
            if (cnt_bus.done) begin
               state_next = pll_en ? ecms_pkg::ST_PLL : ecms_pkg::ST_RUN;
            end
         end
         ecms_pkg::ST_PLL: begin
            if (pll_done) begin
               state_next = ecms_pkg::ST_RUN;
            end
         end
         ecms_pkg::ST_RUN: begin
            if (sleep_cmd_reg) begin
               state_next = ecms_pkg::ST_SLEEP;
            end else if (src_primary && !active_src_reg) begin
               state_next = ext_mode ? ecms_pkg::ST_SWITCH : ecms_pkg::ST_COUNT;
            end
         end
         ecms_pkg::ST_SLEEP: begin
            if (wake_any) begin
               state_next = ext_mode ? ecms_pkg::ST_EXT : ecms_pkg::ST_COUNT;
            end
         end
         ecms_pkg::ST_SWITCH: begin
            if (sw_old_seen_reg && pin_edge) begin
               state_next = ecms_pkg::ST_RUN;
            end
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         state_reg <= ecms_pkg::ST_POR;
      end else begin
         state_reg <= state_next;
      end
   end

   // entering run always lands on the primary source
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         active_src_reg <= 1'b1;
      end else if (state_next == ecms_pkg::ST_RUN && state_reg != ecms_pkg::ST_RUN) begin
         active_src_reg <= 1'b1;
      end else if (state_reg == ecms_pkg::ST_RUN && !src_primary) begin
         active_src_reg <= 1'b0;
      end
   end

   // core frozen everywhere but run, held state kept for resume
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         core_run     <= 1'b0;
         clock_stable <= 1'b0;
      end else begin
         core_run     <= (state_next == ecms_pkg::ST_RUN);
         clock_stable <= (state_next == ecms_pkg::ST_RUN) ||
                         (state_next == ecms_pkg::ST_PLL) ||
                         (state_next == ecms_pkg::ST_SWITCH);
      end
   end
endmodule
`default_nettype wire

// ==== verification/ecms_osc_model.sv ====
/*
   clock source model for clock_input_pin.
   assumes the pin is synchronous to clk_sys.
*/
`timescale 1ns/1ns
`default_nettype none
module ecms_osc_model #(
   parameter int HALF = 3 // clk_sys cycles per half oscillation
) (
   input  wire logic        clk_sys, // system clock
   input  wire logic        run,     // oscillation on
   output var  logic        pin,     // clock input level
   output var  int unsigned n_edge   // rising edges so far
);
   int unsigned cnt = 0;
   initial pin = 1'b0;
   initial n_edge = 0;
   // about 16.7 MHz, inside the medium power band
   always @(posedge clk_sys) begin
      // stopped source holds its level
      if (run) begin
         if (cnt == HALF - 1) begin
            cnt <= 0;
            pin <= !pin;
            if (!pin) n_edge <= n_edge + 1;
         end else begin
            cnt <= cnt + 1;
         end
      end
   end
endmodule
`default_nettype wire

// ==== verification/ecms_top_props.sv ====
/*
   checks on the ports of ecms_top.
   assumes binding into ecms_top.
*/
`timescale 1ns/1ns
`default_nettype none
module ecms_top_props (
   input wire logic       clk_sys,             // system clock
   input wire logic       rst_b,               // async reset, active low
   input wire logic       clock_input_pin,     // external clock level
   input wire logic       core_run,            // core clock gate open
   input wire logic       clock_stable,        // start-up count done
   input wire logic [1:0] amp_gain,            // amplifier gain
   input wire logic       high_power_opt,      // high power option
   input wire logic       clock_output_pin_o,  // output pin level
   input wire logic       clock_output_pin_oe, // output pin driven
   input wire logic       out_gpio_sel         // output pin is gpio
);
   logic        pin_q;
   logic        out_q;
   logic        edge_in;
   logic [10:0] edge_cnt;
   logic [2:0]  half_cnt;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   assign edge_in = clock_input_pin & ~pin_q;
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         pin_q <= 1'b0;
         out_q <= 1'b0;
      end else begin
         pin_q <= clock_input_pin;
         out_q <= clock_output_pin_o;
      end
   end
   // edges since stable last fell
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) edge_cnt <= 11'h000;
      else if (clock_stable) edge_cnt <= 11'h000;
      else if (edge_in && edge_cnt != 11'h7ff) edge_cnt <= edge_cnt + 11'h001;
   end
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) half_cnt <= 3'h0;
      else if (!clock_output_pin_oe) half_cnt <= 3'h0;
      else if (clock_output_pin_o != out_q) half_cnt <= {2'h0, edge_in};
      else if (edge_in && half_cnt != 3'h7) half_cnt <= half_cnt + 3'h1;
   end
   chk_crystal_count:
   assert property ($rose(clock_stable) && !out_gpio_sel && !clock_output_pin_oe
      |-> edge_cnt >= 11'h400) else $error("stable before full count");
   chk_run_needs_stable:
   assert property (core_run |-> clock_stable) else $error("run without stable");
   chk_stable_fall_stop:
   assert property ($fell(clock_stable) |-> !core_run) else $error("run kept on restart");
   chk_gpio_exclusive:
   assert property (clock_output_pin_oe |-> !out_gpio_sel) else $error("pin both uses");
   chk_idle_out_low:
   assert property (!clock_output_pin_oe |-> !clock_output_pin_o) else $error("undriven toggles");
   chk_div_rate:
   assert property (clock_output_pin_oe |-> half_cnt <= 3'h2) else $error("divider too slow");
   chk_hipwr_gain:
   assert property (high_power_opt && !out_gpio_sel && !clock_output_pin_oe
      |-> amp_gain == 2'h3) else $error("high power gain wrong");
   chk_low_gain:
   assert property (amp_gain == 2'h0 && !out_gpio_sel && !clock_output_pin_oe
      |-> !high_power_opt) else $error("lowest gain with high power");
   cover property ($rose(core_run));
   cover property ($fell(clock_stable));
   cover property ($rose(clock_output_pin_o));
endmodule
`default_nettype wire

// ==== verification/ecms_top_tb.sv ====
/*
   self-checking bench for ecms_top.
   assumes design, checker and model compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
`include "ecms_regs.svh"
module automatic ecms_top_tb;
   localparam int HALF = 3;
   logic        clk_sys = 1'b0;
   logic        rst_b = 1'b0;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, lf_osc_tick = 1'b0;
   logic        pwrup_expired = 1'b1, wake_evt = 1'b0, osc_run = 1'b1;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp, amp_gain, rr;
   logic        clock_input_pin, core_run, clock_stable, high_power_opt;
   logic        clock_output_pin_o, clock_output_pin_oe, out_gpio_sel;
   int unsigned n_edge;
   int          errors = 0;
   int          n_compared = 0;
   always #5 clk_sys = ~clk_sys;
   ecms_top #(.PLL_WAIT_CYC(20)) i_ecms_top (.*);
   ecms_osc_model #(.HALF(HALF)) i_ecms_osc_model (.clk_sys, .run(osc_run),
      .pin(clock_input_pin), .n_edge);
   task check(input string what, input logic [33:0] seen, exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask
   task complete_run();
      $display("compared %0d, mismatched %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task hang(input string what);
      check(what, 34'h0, 34'h1);
      complete_run();
   endtask
   task axi_wr(input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge clk_sys);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (k = 0; k < 64 && s_axi_bvalid !== 1'b1; k++) begin
         @(posedge clk_sys);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end
      s_axi_bready <= 1'b0;
      if (k == 64) hang("write response");
   endtask
   task axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int k;
      @(posedge clk_sys);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (k = 0; k < 64 && s_axi_rvalid !== 1'b1; k++) begin
         @(posedge clk_sys);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
      if (k == 64) hang("read response");
   endtask
   // sel high waits for clock_stable, low for core_run
   task wait_for(input logic sel, input int lim, output int k);
      for (k = 0; k < lim && (sel ? clock_stable : core_run) !== 1'b1; k++) @(posedge clk_sys);
      if (k == lim) hang("start wait");
   endtask
   task wait_out(input logic lvl, inout int t);
      int k;
      for (k = 0; k < 100 && clock_output_pin_o !== lvl; k++) begin
         @(posedge clk_sys);
         t++;
      end
      if (k == 100) hang("clock output");
   endtask
   task t_start();
      int k, e0;
      e0 = n_edge;
      repeat (2) @(posedge clk_sys);
      check("reset gain", amp_gain, 2'h1);
      check("reset run", core_run, 1'b0);
      wait_for(1'b0, 20000, k);
      check("start edges", n_edge - e0 >= 1024 && n_edge - e0 <= 1027, 1'b1);
      axi_rd(`ECMS_OFF_CTRL, rd, rr);
      check("ctrl reset", rd, 32'h41);
      axi_rd(`ECMS_OFF_STAT, rd, rr);
      check("run state", rd[4:0], 5'h1e);
      axi_rd(8'h0c, rd, rr);
      check("unmapped", {rr, rd}, {`ECMS_RESP_SLVERR, 32'h0});
      $display("t_start done");
   endtask
   task t_modes();
      logic [1:0] g [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
      for (int c = 0; c < 8; c++) begin
         axi_wr(`ECMS_OFF_CTRL, 32'h40 | 32'(c));
         repeat (3) @(posedge clk_sys);
         if (c < 4) check("gain", amp_gain, g[c]);
         check("hipwr", high_power_opt, c == 2 || c == 4);
         check("oe", clock_output_pin_oe, c == 6);
         check("gpio", out_gpio_sel, c == 4 || c == 5 || c == 7);
      end
      $display("t_modes done");
   endtask
   task t_wake(input logic [31:0] ctrl, input int lo, pw, input bit stop);
      int k, e0;
      axi_wr(`ECMS_OFF_CTRL, ctrl);
      axi_wr(`ECMS_OFF_CMD, 32'h1);
      repeat (3) @(posedge clk_sys);
      check("sleep", {core_run, clock_stable}, 2'b00);
      wake_evt <= 1'b1;
      @(posedge clk_sys);
      wake_evt <= 1'b0;
      e0 = n_edge;
      if (stop) begin
         repeat (300) @(posedge clk_sys);
         osc_run <= 1'b0;
         repeat (2000) @(posedge clk_sys);
         axi_rd(`ECMS_OFF_STAT, rd, rr);
         check("held state", rd[4:0], 5'h03);
         osc_run <= 1'b1;
      end
      wait_for(1'b1, 20000, k);
      check("wake edges", n_edge - e0 >= lo && n_edge - e0 <= lo + 2, 1'b1);
      wait_for(1'b0, 100, k);
      check("gate delay", k >= pw && k <= pw + 2, 1'b1);
      $display("t_wake done");
   endtask
   task t_divided_clock_output();
      int t;
      axi_wr(`ECMS_OFF_CTRL, 32'h46);
      t = 0;
      wait_out(1'b0, t);
      wait_out(1'b1, t);
      t = 0;
      wait_out(1'b0, t);
      wait_out(1'b1, t);
      check("output period", t, 8 * HALF);
      $display("t_divided_clock_output done");
   endtask
   task t_switch();
      int k;
      axi_wr(`ECMS_OFF_CTRL, 32'h04);
      repeat (3) @(posedge clk_sys);
      check("internal run", core_run, 1'b1);
      axi_wr(`ECMS_OFF_CTRL, 32'h44);
      repeat (60) @(posedge clk_sys);
      check("switch hold", core_run, 1'b0);
      lf_osc_tick <= 1'b1;
      @(posedge clk_sys);
      lf_osc_tick <= 1'b0;
      wait_for(1'b0, 2 * HALF + 4, k);
      $display("t_switch done");
   endtask
   initial begin
      repeat (4) @(posedge clk_sys);
      rst_b <= 1'b1;
      t_start();
      t_modes();
      t_wake(32'h44, 8, 0, 1'b0);
      t_wake(32'h46, 8, 0, 1'b0);
      t_wake(32'h51, 1024, 20, 1'b0);
      t_wake(32'h41, 1024, 0, 1'b1);
      t_divided_clock_output();
      t_switch();
      complete_run();
   end
endmodule
bind ecms_top ecms_top_props i_ecms_top_props (.*);
`default_nettype wire
